// *** core/cfr_map.vh ***
`ifndef CFR_MAP_VH
`define CFR_MAP_VH
// ------------------------------------------------------------
// flag register geometry
// ------------------------------------------------------------
`define CFR_WIDTH         32
`define CFR_FIELDS        8
`define CFR_FIELD_W       4
`define CFR_MSB_IDX       5'h1F
`define CFR_TOP_NIB_MASK  32'hF0000000
`define CFR_FLAGS_RESET   32'h00000000
`define CFR_WORD_ZERO     32'h00000000
`define CFR_NIB_ZERO      4'h0
// ------------------------------------------------------------
// dedicated fields
// ------------------------------------------------------------
`define CFR_INT_FIELD     3'h0
`define CFR_FP_FIELD      3'h1
`define CFR_FP_SUM_GROUP  3'h0
// ------------------------------------------------------------
// bit positions inside a field vector [3:0] (field bit 0 is msb)
// ------------------------------------------------------------
`define CFR_NIB_BELOW     2'h3
`define CFR_NIB_ABOVE     2'h2
`define CFR_NIB_MATCH     2'h1
`define CFR_NIB_SUMMARY   2'h0
// ------------------------------------------------------------
// operation codes
// ------------------------------------------------------------
`define CFR_OP_NONE       4'h0
`define CFR_OP_MOVE_GPR   4'h1
`define CFR_OP_COPY_FLD   4'h2
`define CFR_OP_COPY_FP    4'h3
`define CFR_OP_COPY_INTX  4'h4
`define CFR_OP_FLAG_LOGIC 4'h5
`define CFR_OP_CMP_SIGNED 4'h6
`define CFR_OP_CMP_UNSIGN 4'h7
`define CFR_OP_CMP_FLOAT  4'h8
`define CFR_OP_INT_RECORD 4'h9
`define CFR_OP_FP_RECORD  4'hA
`define CFR_OP_READ_ALL   4'hB
`endif

// *** core/cfr_compare.v ***
`timescale 1ns/1ps
`include "cfr_map.vh"
// ------------------------------------------------------------
// compare outcome: {below, above, match, summary or unordered}
// ------------------------------------------------------------
module cfr_compare (
  opA,
  opB,
  isUnsigned,
  isFloat,
  fpLess,
  fpGreater,
  fpEqual,
  fpUnordered,
  summaryIn,
  outcome
);
  input  wire [31:0] opA;
  input  wire [31:0] opB;
  input  wire        isUnsigned;
  input  wire        isFloat;
  input  wire        fpLess;
  input  wire        fpGreater;
  input  wire        fpEqual;
  input  wire        fpUnordered;
  input  wire        summaryIn;
  output reg  [3:0]  outcome;

  wire signedLess;
  wire unsignedLess;
  wire isEqual;
  wire intLess;

  // flipping the sign bits turns a signed order into an unsigned one
  assign signedLess   = {~opA[31], opA[30:0]} < {~opB[31], opB[30:0]};
  assign unsignedLess = opA < opB;
  assign isEqual      = opA == opB;
  assign intLess      = isUnsigned ? unsignedLess : signedLess;

  // pick integer or floating-point outcome
  always @* begin
    outcome = `CFR_NIB_ZERO;
    if (isFloat) begin
      outcome[`CFR_NIB_BELOW]   = fpLess;
      outcome[`CFR_NIB_ABOVE]   = fpGreater;
      outcome[`CFR_NIB_MATCH]   = fpEqual;
      outcome[`CFR_NIB_SUMMARY] = fpUnordered;
    end else begin
      outcome[`CFR_NIB_BELOW]   = intLess;
      outcome[`CFR_NIB_ABOVE]   = ~intLess & ~isEqual;
      outcome[`CFR_NIB_MATCH]   = isEqual;
      outcome[`CFR_NIB_SUMMARY] = summaryIn;
    end
  end
endmodule

// *** core/cfr_flags.v ***
`timescale 1ns/1ps
`include "cfr_map.vh"
module cfr_flags (
  clock,
  reset_n,
  clockEn,
  opValid,
  opCode,
  fieldMask,
  srcField,
  dstField,
  fpGroup,
  srcBitA,
  srcBitB,
  dstBit,
  logicTable,
  generalIn,
  cmpOpA,
  cmpOpB,
  intResult,
  intOverflowSet,
  intExcBits,
  fpStatus,
  fpLess,
  fpGreater,
  fpEqual,
  fpUnordered,
  soClear,
  condFlags,
  readData,
  readValid,
  summaryOverflow
);
  // ------------------------------------------------------------
  // ports
  // ------------------------------------------------------------
  input  wire        clock;
  input  wire        reset_n;
  input  wire        clockEn;         // low freezes all state
  input  wire        opValid;         // one operation this cycle
  input  wire [3:0]  opCode;          // which operation
  input  wire [7:0]  fieldMask;       // bit 7 selects field 0
  input  wire [2:0]  srcField;        // source field number
  input  wire [2:0]  dstField;        // destination field number
  input  wire [2:0]  fpGroup;         // fp status nibble number
  input  wire [4:0]  srcBitA;         // first flag bit, msb-first
  input  wire [4:0]  srcBitB;         // second flag bit, msb-first
  input  wire [4:0]  dstBit;          // target flag bit, msb-first
  input  wire [3:0]  logicTable;      // truth table indexed {a,b}
  input  wire [31:0] generalIn;       // general register value
  input  wire [31:0] cmpOpA;          // first compare operand
  input  wire [31:0] cmpOpB;          // second operand or immediate
  input  wire [31:0] intResult;       // integer destination result
  input  wire        intOverflowSet;  // this instruction overflowed
  input  wire [2:0]  intExcBits;      // exception flags after summary
  input  wire [31:0] fpStatus;        // fp status, final state
  input  wire        fpLess;          // fp compare: a < b
  input  wire        fpGreater;       // fp compare: a > b
  input  wire        fpEqual;         // fp compare: a = b
  input  wire        fpUnordered;     // fp compare: a nan seen
  input  wire        soClear;         // software clears summary
  output reg  [31:0] condFlags;
  output reg  [31:0] readData;
  output reg         readValid;
  output reg         summaryOverflow;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // field n of a msb-first word
  function [3:0] getField;
    input [31:0] word;
    input [2:0]  n;
    reg   [31:0] tmp;
    begin
      tmp      = word << {n, 2'h0};
      getField = tmp[31:28];
    end
  endfunction

  // word with field n replaced
  function [31:0] putField;
    input [31:0] word;
    input [2:0]  n;
    input [3:0]  nib;
    reg   [31:0] mask;
    reg   [31:0] data;
    begin
      mask     = `CFR_TOP_NIB_MASK >> {n, 2'h0};
      data     = {nib, 28'h0000000} >> {n, 2'h0};
      putField = (word & ~mask) | data;
    end
  endfunction

  // msb-first bit number to vector index
  function [4:0] bitPos;
    input [4:0] k;
    begin
      bitPos = `CFR_MSB_IDX - k;
    end
  endfunction

  // eight field selects widened to a 32-bit mask
  function [31:0] expandMask;
    input [7:0] sel;
    integer     i;
    begin
      expandMask = `CFR_WORD_ZERO;
      for (i = 0; i < `CFR_FIELDS; i = i + 1) begin
        if (sel[`CFR_FIELDS - 1 - i]) begin
          expandMask = expandMask | (`CFR_TOP_NIB_MASK >> (i * `CFR_FIELD_W));
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [31:0] flags_q;
  reg  [31:0] flags_d;
  reg  [31:0] readData_q;
  reg  [31:0] readData_d;
  reg         readValid_q;
  reg         readValid_d;
  reg         summary_q;
  reg         summary_d;
  reg         fieldWrite;    // one whole field is replaced
  reg  [2:0]  fieldSel;      // which field
  reg  [3:0]  fieldNib;      // its new contents

  wire        active;
  wire        overflowNow;
  wire        summaryFinal;
  wire        cmpUnsigned;
  wire        cmpFloat;
  wire [3:0]  cmpOutcome;
  wire [3:0]  recOutcome;
  wire [3:0]  fpSummaryNib;
  wire [31:0] moveMask;
  wire        logicA;
  wire        logicB;
  wire        logicResult;

  assign active = clockEn & opValid;

  // ------------------------------------------------------------
  // summary overflow
  // ------------------------------------------------------------

  // the value after this instruction, its own overflow included
  assign overflowNow  = active & intOverflowSet;
  assign summaryFinal = summary_q | overflowNow;

  // sticky: set wins over a clear in the same cycle
  always @* begin
    summary_d = summary_q;
    if (overflowNow) begin
      summary_d = 1'h1;
    end else if (soClear) begin
      summary_d = 1'h0;
    end
  end

  // ------------------------------------------------------------
  // compare and record outcomes
  // ------------------------------------------------------------
  assign cmpUnsigned = (opCode == `CFR_OP_CMP_UNSIGN);
  assign cmpFloat    = (opCode == `CFR_OP_CMP_FLOAT);

  // explicit compare, integer or floating-point
  cfr_compare uCompare (
    .opA         (cmpOpA),
    .opB         (cmpOpB),
    .isUnsigned  (cmpUnsigned),
    .isFloat     (cmpFloat),
    .fpLess      (fpLess),
    .fpGreater   (fpGreater),
    .fpEqual     (fpEqual),
    .fpUnordered (fpUnordered),
    .summaryIn   (summaryFinal),
    .outcome     (cmpOutcome)
  );

  // implicit record: signed compare of the result against zero
  cfr_compare uRecord (
    .opA         (intResult),
    .opB         (`CFR_WORD_ZERO),
    .isUnsigned  (1'h0),
    .isFloat     (1'h0),
    .fpLess      (1'h0),
    .fpGreater   (1'h0),
    .fpEqual     (1'h0),
    .fpUnordered (1'h0),
    .summaryIn   (summaryFinal),
    .outcome     (recOutcome)
  );

  // ------------------------------------------------------------
  // flag logic operands
  // ------------------------------------------------------------
  assign moveMask     = expandMask(fieldMask);
  assign fpSummaryNib = getField(fpStatus, `CFR_FP_SUM_GROUP);
  assign logicA       = flags_q[bitPos(srcBitA)];
  assign logicB       = flags_q[bitPos(srcBitB)];
  assign logicResult  = logicTable[{logicA, logicB}];

  // ------------------------------------------------------------
  // single-field writes
  // ------------------------------------------------------------

  // one-field operations: pick the field and its new nibble
  always @* begin
    fieldWrite = 1'h0;
    fieldSel   = dstField;
    fieldNib   = `CFR_NIB_ZERO;
    case (opCode)
      // copies from another field or a status register
      `CFR_OP_COPY_FLD: begin
        fieldWrite = 1'h1;
        fieldNib   = getField(flags_q, srcField);
      end
      `CFR_OP_COPY_FP: begin
        fieldWrite = 1'h1;
        fieldNib   = getField(fpStatus, fpGroup);
      end
      `CFR_OP_COPY_INTX: begin
        fieldWrite = 1'h1;
        fieldNib   = {summaryFinal, intExcBits};
      end
      // explicit compares into the named field
      `CFR_OP_CMP_SIGNED: begin
        fieldWrite = 1'h1;
        fieldNib   = cmpOutcome;
      end
      `CFR_OP_CMP_UNSIGN: begin
        fieldWrite = 1'h1;
        fieldNib   = cmpOutcome;
      end
      `CFR_OP_CMP_FLOAT: begin
        fieldWrite = 1'h1;
        fieldNib   = cmpOutcome;
      end
      // implicit records into the dedicated fields
      `CFR_OP_INT_RECORD: begin
        // undefined results simply pass through, which is allowed
        fieldWrite = 1'h1;
        fieldSel   = `CFR_INT_FIELD;
        fieldNib   = recOutcome;
      end
      `CFR_OP_FP_RECORD: begin
        fieldWrite = 1'h1;
        fieldSel   = `CFR_FP_FIELD;
        fieldNib   = fpSummaryNib;
      end
      default: begin
        fieldWrite = 1'h0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next flag value
  // ------------------------------------------------------------

  // every write of one operation lands in a single update
  always @* begin
    flags_d = flags_q;
    if (active) begin
      case (opCode)
        `CFR_OP_MOVE_GPR: begin
          flags_d = (flags_q & ~moveMask) | (generalIn & moveMask);
        end
        `CFR_OP_FLAG_LOGIC: begin
          flags_d[bitPos(dstBit)] = logicResult;
        end
        default: begin
          if (fieldWrite) begin
            flags_d = putField(flags_q, fieldSel, fieldNib);
          end
        end
      endcase
    end
  end

  // read path: snapshot of the whole word, flagged for one cycle
  always @* begin
    readData_d  = readData_q;
    readValid_d = 1'h0;
    if (active && (opCode == `CFR_OP_READ_ALL)) begin
      readData_d  = flags_q;
      readValid_d = 1'h1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------

  // eight msb-first fields held as one word
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_q     <= `CFR_FLAGS_RESET;
      readData_q  <= `CFR_WORD_ZERO;
      readValid_q <= 1'h0;
      summary_q   <= 1'h0;
    end else if (clockEn) begin
      flags_q     <= flags_d;
      readData_q  <= readData_d;
      readValid_q <= readValid_d;
      summary_q   <= summary_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  always @* begin
    condFlags       = flags_q;
    readData        = readData_q;
    readValid       = readValid_q;
    summaryOverflow = summary_q;
  end
endmodule

// *** test/cfr_fpu_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// fpu stand-in: small signed operands, nan marker
// ------------------------------------------------------------
module cfr_fpu_model (
  input  wire signed [7:0] fpA,
  input  wire signed [7:0] fpB,
  input  wire              nanSeen,
  output wire              fpLess,
  output wire              fpGreater,
  output wire              fpEqual,
  output wire              fpUnordered
);
  // ordered outcomes only when both operands are numbers
  assign fpLess      = !nanSeen && (fpA < fpB);
  assign fpGreater   = !nanSeen && (fpA > fpB);
  assign fpEqual     = !nanSeen && (fpA == fpB);
  assign fpUnordered = nanSeen;
endmodule

// *** test/cfr_flags_properties.sv ***
`timescale 1ns/1ps
`include "cfr_map.vh"
// ------------------------------------------------------------
// port-level checks of the flag register
// ------------------------------------------------------------
module cfr_flags_properties (
  input wire        clock,
  input wire        reset_n,
  input wire        clockEn,
  input wire        opValid,
  input wire [3:0]  opCode,
  input wire [7:0]  fieldMask,
  input wire [31:0] generalIn,
  input wire [31:0] intResult,
  input wire        intOverflowSet,
  input wire [31:0] fpStatus,
  input wire        soClear,
  input wire [31:0] condFlags,
  input wire [31:0] readData,
  input wire        readValid,
  input wire        summaryOverflow
);
  wire act = clockEn && opValid;
  wire rd  = act && (opCode == `CFR_OP_READ_ALL);
  wire rec = act && (opCode == `CFR_OP_INT_RECORD);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // operation effects one edge after they are taken
  a_freeze_hold: assert property (!clockEn |=> $stable(condFlags))
    else $error("flags moved while frozen");
  a_idle_keep: assert property (clockEn && !opValid |=> $stable(condFlags))
    else $error("flags moved without an operation");
  a_move_all: assert property (act && opCode == `CFR_OP_MOVE_GPR && fieldMask == 8'hFF
    |=> condFlags == $past(generalIn))
    else $error("full move wrong");
  a_read_copy: assert property (rd |=> readValid && readData == $past(condFlags))
    else $error("read copy wrong");
  a_read_drop: assert property (readValid && clockEn && !rd |=> !readValid)
    else $error("read pulse too long");
  a_so_set: assert property (act && intOverflowSet |=> summaryOverflow)
    else $error("summary not set");
  a_so_hold: assert property (clockEn && !soClear && !(act && intOverflowSet)
    |=> summaryOverflow == $past(summaryOverflow))
    else $error("summary changed");
  a_int_zero: assert property (rec && intResult == 32'h00000000
    |=> condFlags[31:29] == 3'h1)
    else $error("zero result bits wrong");
  a_int_summary: assert property (rec && !soClear
    |=> condFlags[28] == ($past(summaryOverflow) | $past(intOverflowSet)))
    else $error("field 0 summary wrong");
  a_fp_record: assert property (act && opCode == `CFR_OP_FP_RECORD
    |=> condFlags[27:24] == $past(fpStatus[31:28]))
    else $error("fp record wrong");
  c_read: cover property (rd ##1 readValid);
  c_rec: cover property (rec && intOverflowSet);
  c_freeze: cover property (!clockEn && opValid);
endmodule

bind cfr_flags cfr_flags_properties chk (.clock(clock), .reset_n(reset_n), .clockEn(clockEn),
  .opValid(opValid), .opCode(opCode), .fieldMask(fieldMask), .generalIn(generalIn),
  .intResult(intResult), .intOverflowSet(intOverflowSet), .fpStatus(fpStatus),
  .soClear(soClear), .condFlags(condFlags), .readData(readData), .readValid(readValid),
  .summaryOverflow(summaryOverflow));

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "cfr_map.vh"
module tb_top;
  logic              clock, reset_n, clockEn, opValid, intOverflowSet, soClear, nanSeen;
  logic [3:0]        opCode, logicTable;
  logic [7:0]        fieldMask;
  logic [2:0]        srcField, dstField, fpGroup, intExcBits;
  logic [4:0]        srcBitA, srcBitB, dstBit;
  logic [31:0]       generalIn, cmpOpA, cmpOpB, intResult, fpStatus;
  logic signed [7:0] fpA, fpB;
  wire               fpLess, fpGreater, fpEqual, fpUnordered, readValid, summaryOverflow;
  wire [31:0]        condFlags, readData;
  int                n_fail, n_checks, i;
  logic [11:0]       tabs = 12'h8E6;  // and, or, xor
  logic [2:0]        res = 3'b011;    // their results for a=1, b=0

  cfr_flags uut (.clock(clock), .reset_n(reset_n), .clockEn(clockEn), .opValid(opValid),
    .opCode(opCode), .fieldMask(fieldMask), .srcField(srcField), .dstField(dstField),
    .fpGroup(fpGroup), .srcBitA(srcBitA), .srcBitB(srcBitB), .dstBit(dstBit),
    .logicTable(logicTable), .generalIn(generalIn), .cmpOpA(cmpOpA), .cmpOpB(cmpOpB),
    .intResult(intResult), .intOverflowSet(intOverflowSet), .intExcBits(intExcBits),
    .fpStatus(fpStatus), .fpLess(fpLess), .fpGreater(fpGreater), .fpEqual(fpEqual),
    .fpUnordered(fpUnordered), .soClear(soClear), .condFlags(condFlags),
    .readData(readData), .readValid(readValid), .summaryOverflow(summaryOverflow));
  cfr_fpu_model fpu (.fpA(fpA), .fpB(fpB), .nanSeen(nanSeen), .fpLess(fpLess),
    .fpGreater(fpGreater), .fpEqual(fpEqual), .fpUnordered(fpUnordered));

  // ------------------------------------------------------------
  // clock, watchdog and helpers
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic [31:0] fld(input int n);
    fld = {28'h0, condFlags[31-4*n -: 4]};
  endfunction
  // raise one operation; caller sets operands in the same step
  task automatic issue(input [3:0] c);
    @(posedge clock);
    opValid <= 1'b1;
    opCode  <= c;
  endtask
  // let the taking edge pass, then drop the one-shot inputs
  task automatic fin;
    @(posedge clock);
    opValid        <= 1'b0;
    soClear        <= 1'b0;
    intOverflowSet <= 1'b0;
    #1;
  endtask
  task automatic cmp(input [3:0] c, input [31:0] a, input [31:0] b, input nan,
                     input [31:0] exp);
    issue(c);
    dstField <= 3'h3;
    cmpOpA   <= a;
    cmpOpB   <= b;
    fpA      <= a[7:0];
    fpB      <= b[7:0];
    nanSeen  <= nan;
    fin;
    chk(fld(3), exp);
  endtask
  task automatic rec(input [31:0] r, input ov, input [31:0] exp);
    issue(`CFR_OP_INT_RECORD);
    intResult      <= r;
    intOverflowSet <= ov;
    fin;
    chk(fld(0), exp);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {reset_n, opValid, intOverflowSet, soClear, nanSeen, opCode, logicTable} = '0;
    {fieldMask, srcField, dstField, fpGroup, intExcBits, srcBitA, srcBitB, dstBit} = '0;
    {generalIn, cmpOpA, cmpOpB, intResult, fpStatus, fpA, fpB} = '0;
    clockEn = 1'b1;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    issue(`CFR_OP_MOVE_GPR);
    fieldMask <= 8'hFF;
    generalIn <= 32'h12345678;
    fin;
    chk(condFlags, 32'h12345678);
    issue(`CFR_OP_MOVE_GPR);
    fieldMask <= 8'h81;
    generalIn <= 32'hABCDEF09;
    fin;
    chk(condFlags, 32'hA2345679);
    issue(`CFR_OP_COPY_FLD);
    srcField <= 3'h0;
    dstField <= 3'h5;
    fin;
    chk(condFlags, 32'hA2345A79);
    issue(`CFR_OP_COPY_FP);
    fpStatus <= 32'h0000C000;
    fpGroup  <= 3'h4;
    dstField <= 3'h7;
    fin;
    chk(condFlags, 32'hA2345A7C);
    issue(`CFR_OP_COPY_INTX);
    intExcBits <= 3'h5;
    dstField   <= 3'h2;
    fin;
    chk(condFlags, 32'hA2545A7C);
    for (i = 0; i < 3; i++) begin
      issue(`CFR_OP_FLAG_LOGIC);
      {srcBitA, srcBitB, dstBit} <= {5'h00, 5'h01, 5'h1F};
      logicTable <= tabs[11-4*i -: 4];
      fin;
      chk(condFlags, {31'h512A2D3E, res[2-i]});
    end
    cmp(`CFR_OP_CMP_SIGNED, 32'hFFFFFFFF, 32'h1, 1'b0, 32'h8);
    cmp(`CFR_OP_CMP_UNSIGN, 32'hFFFFFFFF, 32'h1, 1'b0, 32'h4);
    cmp(`CFR_OP_CMP_SIGNED, 32'h5, 32'h5, 1'b0, 32'h2);
    cmp(`CFR_OP_CMP_FLOAT, 32'hFD, 32'h2, 1'b0, 32'h8);
    cmp(`CFR_OP_CMP_FLOAT, 32'h2, 32'h2, 1'b1, 32'h1);
    rec(32'h0, 1'b1, 32'h3);
    chk({31'h0, summaryOverflow}, 32'h1);
    rec(32'h80000000, 1'b0, 32'h9);
    cmp(`CFR_OP_CMP_SIGNED, 32'h2, 32'h1, 1'b0, 32'h5);
    issue(`CFR_OP_NONE);
    soClear <= 1'b1;
    fin;
    chk({31'h0, summaryOverflow}, 32'h0);
    rec(32'h7, 1'b0, 32'h4);
    issue(`CFR_OP_FP_RECORD);
    fpStatus <= 32'hB0000000;
    fin;
    chk(fld(1), 32'hB);
    issue(`CFR_OP_READ_ALL);
    fin;
    chk(readData, 32'h4B555A7D);
    chk({31'h0, readValid}, 32'h1);
    @(posedge clock);
    #1;
    chk({31'h0, readValid}, 32'h0);
    issue(`CFR_OP_MOVE_GPR);
    clockEn   <= 1'b0;
    fieldMask <= 8'hFF;
    generalIn <= 32'h0;
    fin;
    chk(condFlags, 32'h4B555A7D);
    @(posedge clock);
    clockEn <= 1'b1;
    tally_and_finish;
  end
endmodule
